/* verilog/mlcd_defines.svh */
// timing constants and encodings for the multiplexed lcd waveform generator
`ifndef MLCD_DEFINES_SVH
`define MLCD_DEFINES_SVH

// -----------------------------------------------------------------------------
// multiplex modes
// -----------------------------------------------------------------------------
`define MLCD_MODE_STATIC 2'h0
`define MLCD_MODE_DUPLEX 2'h1
`define MLCD_MODE_QUAD   2'h2

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define MLCD_CLK_HZ        125000000
`define MLCD_FRAME_MIN_HZ  30
`define MLCD_FRAME_MAX_HZ  200
`define MLCD_EVENTS_PER_PH 4
`define MLCD_PHASES_QUAD   4
`define MLCD_ACTIVE_DEF    32'h0001E848
`define MLCD_DEAD_DEF      32'h00000000

`endif

/* verilog/mlcd_pkg.sv */
// types shared by the multiplexed lcd waveform generator
package mlcd_pkg;

    // -------------------------------------------------------------------------
    // sub-phase sequence within one phase
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MLCD_SUB_FIRST = 2'b00,
        MLCD_SUB_DEAD1 = 2'b01,
        MLCD_SUB_INV   = 2'b10,
        MLCD_SUB_DEAD2 = 2'b11
    } mlcd_sub_type;

    // -------------------------------------------------------------------------
    // frame configuration, latched at frame boundary
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  mode;
        logic        raise_rms;
        logic [31:0] active_cmp;
        logic [31:0] dead_cmp;
    } mlcd_cfg_type;

endpackage

/* verilog/mlcd_wavegen.sv */
// multiplexed lcd segment and common waveform generator
// Contract
// RQ1: static mode: common is 50% square wave
// RQ2: static: on segment inverted, off equals common
// RQ3: duplex uses two commons, shared segments
// RQ4: quadruplex uses four commons, shared segments
// RQ5: segments only ever driven low or high
// RQ6: common mid level is high impedance
// RQ7: inactive commons held at mid level
// RQ8: drive polarity alternates, zero net dc
// RQ9: frame rate typically 30 to 200 hz
// RQ10: quadruplex frame has four ordered phases
// RQ11: common active only in own phase
// RQ12: each phase: active then dead interval
// RQ13: free timer against two compare values
// RQ14: all phases equal duration
// RQ15: first event: on high, common low
// RQ16: second event: segments inverted, common high
// RQ17: dead: all low, or mirrored for raise
// RQ18: sixteen events per frame, four per phase
// RQ19: one bit per segment per common, sampled
// RQ20: config changes apply at frame boundary
`timescale 1ns/10ps
`include "mlcd_defines.svh"

module mlcd_wavegen #(
    parameter int NSEG    = 32,
    parameter int NCOM    = 4,
    parameter int TMR_W   = 32
) (
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    input  wire logic [1:0]              mode_i,
    input  wire logic                    raise_rms_i,
    input  wire logic [TMR_W-1:0]        active_cmp_i,
    input  wire logic [TMR_W-1:0]        dead_cmp_i,
    input  wire logic [NCOM*NSEG-1:0]    seg_bits_i,
    output logic [NSEG-1:0]              seg_o,
    output logic [NCOM-1:0]              com_o,
    output logic [NCOM-1:0]              com_oe_o,
    output logic                         first_drive_event_o,
    output logic                         inverted_drive_event_o,
    output logic                         dead_interval_event_o,
    output logic                         frame_start_o
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    logic [TMR_W-1:0]        tmr_q;
    logic [TMR_W-1:0]        tmr_d;
    mlcd_pkg::mlcd_sub_type  sub_q;
    mlcd_pkg::mlcd_sub_type  sub_d;
    logic [1:0]              ph_q;
    logic [1:0]              ph_d;
    mlcd_pkg::mlcd_cfg_type  cfg_q;
    mlcd_pkg::mlcd_cfg_type  cfg_d;
    logic [NSEG-1:0]         bits_q;
    logic [NSEG-1:0]         bits_d;
    logic [NSEG-1:0]         seg_q;
    logic [NSEG-1:0]         seg_d;
    logic [NCOM-1:0]         com_q;
    logic [NCOM-1:0]         com_d;
    logic [NCOM-1:0]         oe_q;
    logic [NCOM-1:0]         oe_d;
    logic                    ev1_q;
    logic                    ev1_d;
    logic                    ev2_q;
    logic                    ev2_d;
    logic                    evd_q;
    logic                    evd_d;
    logic                    fs_q;
    logic                    fs_d;

    // -------------------------------------------------------------------------
    // combinational helpers
    // -------------------------------------------------------------------------
    logic [TMR_W-1:0]        cmp_sel;
    logic                    hit;
    logic [1:0]              last_ph;
    logic                    dead_skip;
    logic                    new_frame;
    logic [NSEG-1:0]         row [NCOM];

    // -------------------------------------------------------------------------
    // display bit rows, one per common
    // -------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCOM; g++) begin : g_row
            assign row[g] = seg_bits_i[g*NSEG +: NSEG];
        end
    endgenerate

    // -------------------------------------------------------------------------
    // mode decode
    // -------------------------------------------------------------------------
    always_comb begin
        // static mode has one phase, duplex two, quadruplex four [RQ3] [RQ4] [RQ10]
        if (cfg_q.mode == `MLCD_MODE_STATIC) begin
            last_ph = 2'h0;
        end else if (cfg_q.mode == `MLCD_MODE_DUPLEX) begin
            last_ph = 2'h1;
        end else begin
            // mode 3 runs as quadruplex rather than stalling the glass
            last_ph = 2'h3;
        end
        // static mode has no dead time so the common stays a true 50% square [RQ1]
        dead_skip = (cfg_q.mode == `MLCD_MODE_STATIC) || (cfg_q.dead_cmp == '0);
    end

    // -------------------------------------------------------------------------
    // interval timer
    // -------------------------------------------------------------------------
    always_comb begin
        // same two compare values every phase keep phases equal [RQ13] [RQ14]
        cmp_sel = sub_q[0] ? cfg_q.dead_cmp : cfg_q.active_cmp;
        // a zero compare acts as one cycle instead of a full timer wrap
        hit     = (tmr_q >= cmp_sel - TMR_W'(1)) || (cmp_sel == '0);
        if (hit) begin
            tmr_d = '0;
        end else begin
            tmr_d = tmr_q + TMR_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // -------------------------------------------------------------------------
    // sub-phase and phase sequencer
    // -------------------------------------------------------------------------
    always_comb begin
        sub_d     = sub_q;
        ph_d      = ph_q;
        new_frame = 1'b0;
        if (hit) begin
            // four events per phase, sixteen per quadruplex frame, except under dead_skip: two per phase, eight per frame [RQ18] [RQ12]
            case (sub_q)
                mlcd_pkg::MLCD_SUB_FIRST: begin
                    sub_d = dead_skip ? mlcd_pkg::MLCD_SUB_INV : mlcd_pkg::MLCD_SUB_DEAD1;
                end
                mlcd_pkg::MLCD_SUB_DEAD1: begin
                    sub_d = mlcd_pkg::MLCD_SUB_INV;
                end
                mlcd_pkg::MLCD_SUB_INV: begin
                    sub_d = dead_skip ? mlcd_pkg::MLCD_SUB_FIRST : mlcd_pkg::MLCD_SUB_DEAD2;
                end
                default: begin
                    sub_d = mlcd_pkg::MLCD_SUB_FIRST;
                end
            endcase
            if (sub_d == mlcd_pkg::MLCD_SUB_FIRST) begin
                ph_d      = (ph_q >= last_ph) ? 2'h0 : ph_q + 2'h1; // [RQ10]
                new_frame = (ph_d == 2'h0);
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            // parked at a frame end so the first edge opens phase 0
            sub_q <= mlcd_pkg::MLCD_SUB_DEAD2;
            ph_q  <= 2'h3;
        end else begin
            sub_q <= sub_d;
            ph_q  <= ph_d;
        end
    end

    // -------------------------------------------------------------------------
    // frame configuration
    // -------------------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        if (new_frame) begin
            // config only moves at a frame edge to avoid a lopsided frame [RQ20]
            cfg_d.mode       = mode_i;
            cfg_d.raise_rms  = raise_rms_i;
            cfg_d.active_cmp = active_cmp_i;
            cfg_d.dead_cmp   = dead_cmp_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            // reset compare gives a 125 hz quadruplex frame [RQ9]
            cfg_q <= '{mode: `MLCD_MODE_QUAD, raise_rms: 1'b0,
                       active_cmp: TMR_W'(`MLCD_ACTIVE_DEF),
                       dead_cmp: TMR_W'(`MLCD_DEAD_DEF)};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // -------------------------------------------------------------------------
    // segment and common drive
    // -------------------------------------------------------------------------
    always_comb begin
        bits_d = bits_q;
        seg_d  = seg_q;
        com_d  = com_q;
        oe_d   = oe_q;
        if (hit) begin
            // drive halves release all commons to the divider except the phase owner; dead intervals drive all [RQ6] [RQ7] [RQ11]
            oe_d  = '0;
            com_d = '0;
            case (sub_d)
                mlcd_pkg::MLCD_SUB_FIRST: begin
                    // sample the row of the upcoming phase [RQ19]
                    bits_d     = row[ph_d];
                    // on segments high, owner common low [RQ15] [RQ2]
                    seg_d      = row[ph_d];
                    oe_d[ph_d] = 1'b1;
                end
                mlcd_pkg::MLCD_SUB_INV: begin
                    // inverted half gives zero net dc per phase [RQ16] [RQ8]
                    seg_d       = ~bits_q;
                    com_d[ph_q] = 1'b1;
                    oe_d[ph_q]  = 1'b1;
                end
                mlcd_pkg::MLCD_SUB_DEAD1: begin
                    // commons low; raise mode puts segments opposite [RQ17]
                    seg_d = cfg_q.raise_rms ? '1 : '0;
                    oe_d  = '1;
                end
                default: begin
                    // commons high in raise mode, segments opposite [RQ17]
                    seg_d = '0;
                    com_d = cfg_q.raise_rms ? '1 : '0;
                    oe_d  = '1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bits_q <= '0;
            seg_q  <= '0;
            com_q  <= '0;
            oe_q   <= '0;
        end else begin
            bits_q <= bits_d;
            seg_q  <= seg_d;
            com_q  <= com_d;
            oe_q   <= oe_d;
        end
    end

    // -------------------------------------------------------------------------
    // event pulses
    // -------------------------------------------------------------------------
    always_comb begin
        ev1_d = 1'b0;
        ev2_d = 1'b0;
        evd_d = 1'b0;
        // frame pulse rides with the first event of phase 0
        fs_d  = new_frame;
        if (hit) begin
            case (sub_d)
                mlcd_pkg::MLCD_SUB_FIRST: begin
                    ev1_d = 1'b1;
                end
                mlcd_pkg::MLCD_SUB_INV: begin
                    ev2_d = 1'b1;
                end
                default: begin
                    evd_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ev1_q <= 1'b0;
            ev2_q <= 1'b0;
            evd_q <= 1'b0;
            fs_q  <= 1'b0;
        end else begin
            ev1_q <= ev1_d;
            ev2_q <= ev2_d;
            evd_q <= evd_d;
            fs_q  <= fs_d;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    // segments are always actively driven, never floated [RQ5]
    assign seg_o                  = seg_q;
    assign com_o                  = com_q;
    assign com_oe_o               = oe_q;
    assign first_drive_event_o    = ev1_q;
    assign inverted_drive_event_o = ev2_q;
    assign dead_interval_event_o  = evd_q;
    assign frame_start_o          = fs_q;

endmodule

/* verif/mlcd_wavegen_chk.sv */
// assertion checker for the lcd waveform generator
`timescale 1ns/10ps
module mlcd_wavegen_chk #(
    parameter int NSEG = 32,
    parameter int NCOM = 4
) (
    input wire logic            clk_i,
    input wire logic            arst_n_i,
    input wire logic [NSEG-1:0] seg_o,
    input wire logic [NCOM-1:0] com_o,
    input wire logic [NCOM-1:0] com_oe_o,
    input wire logic            first_drive_event_o,
    input wire logic            inverted_drive_event_o,
    input wire logic            dead_interval_event_o,
    input wire logic            frame_start_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [NCOM-1:0] last_oe_q;
    logic [NSEG-1:0] first_seg_q;
    // remembers the last first-half drive so rotation and inversion can be judged
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_oe_q   <= '0;
            first_seg_q <= '0;
        end else if (first_drive_event_o) begin
            last_oe_q   <= com_oe_o;
            first_seg_q <= seg_o;
        end
    end
    property p_first; first_drive_event_o |-> $onehot(com_oe_o) && (com_o & com_oe_o) == '0; endproperty
    a_first: assert property (p_first) else $error("first half drive wrong");
    property p_inv; inverted_drive_event_o |-> $onehot(com_oe_o) && (com_o & com_oe_o) == com_oe_o; endproperty
    a_inv: assert property (p_inv) else $error("inverted half drive wrong");
    property p_inv_seg; inverted_drive_event_o |-> seg_o == ~first_seg_q; endproperty
    a_inv_seg: assert property (p_inv_seg) else $error("segments not inverted");
    property p_dead; dead_interval_event_o |-> (seg_o == '0 || seg_o == '1) && ((com_o & com_oe_o) == '0 || seg_o == '0); endproperty
    a_dead: assert property (p_dead) else $error("dead interval levels wrong");
    property p_frame; frame_start_o |-> first_drive_event_o && com_oe_o == NCOM'(1); endproperty
    a_frame: assert property (p_frame) else $error("frame does not open on common 0");
    property p_excl; $onehot0({first_drive_event_o, inverted_drive_event_o, dead_interval_event_o}); endproperty
    a_excl: assert property (p_excl) else $error("events overlap");
    property p_stable; !(first_drive_event_o || inverted_drive_event_o || dead_interval_event_o) |-> $stable({seg_o, com_o, com_oe_o}); endproperty
    a_stable: assert property (p_stable) else $error("drive moved between events");
    property p_rot; first_drive_event_o && !frame_start_o |-> com_oe_o == (last_oe_q << 1); endproperty
    a_rot: assert property (p_rot) else $error("phase order wrong");
    c_frame: cover property (frame_start_o);
    c_raise: cover property (dead_interval_event_o && seg_o == '1);
    c_inv: cover property (inverted_drive_event_o && !com_oe_o[0]);
endmodule
bind mlcd_wavegen mlcd_wavegen_chk #(.NSEG(NSEG), .NCOM(NCOM)) u_chk (.*);

/* verif/mlcd_glass.sv */
// display glass model: divider-resolved common 0 and net dc on its first cell
`timescale 1ns/10ps
module mlcd_glass #(
    parameter int NSEG = 4
) (
    input wire logic            clk_i,
    input wire logic [NSEG-1:0] seg_i,
    input wire logic [3:0]      com_i,
    input wire logic [3:0]      oe_i,
    output int                  dc_o
);
    // half-supply units; a released common floats to the divider midpoint
    int lvl;
    int acc = 0;
    assign lvl = oe_i[0] ? 2 * com_i[0] : 1;
    assign dc_o = acc;
    always @(posedge clk_i) acc <= acc + 2 * seg_i[0] - lvl;
endmodule

/* verif/mlcd_wavegen_tb_top.sv */
// self-checking bench for the lcd waveform generator
`timescale 1ns/10ps
module mlcd_wavegen_tb_top;
    localparam int NS = 4;
    typedef struct packed {
        logic [1:0] kind; logic fs; logic [NS-1:0] seg;
        logic [3:0] com; logic [3:0] oe; logic [3:0] msk; logic [31:0] len;
    } mlcd_note_type;
    logic clk = 1'b0, arst_n = 1'b0, raise = 1'b0, e1, e2, ed, fs;
    logic [1:0] mode = 2'h2;
    logic [31:0] acmp = 32'h4, dcmp = 32'h2;
    logic [4*NS-1:0] bits = '0;
    logic [NS-1:0] seg;
    logic [3:0] com, oe;
    int dc, seed = 77, miscompares = 0, cmp_count = 0, gap = 0, plen = 0, dcp = 0;
    bit dcp_ok = 0;
    mlcd_note_type q[$], e;
    int tm[6] = '{2, 2, 3, 1, 0, 2};
    bit tr[6] = '{1, 0, 1, 1, 0, 0};
    int ta[6] = '{4, 3, 1, 2, 5, 0};
    int td[6] = '{2, 1, 0, 3, 2, 1};
    always #4 clk = ~clk;
    mlcd_wavegen #(.NSEG(NS)) u_dut (.clk_i(clk), .arst_n_i(arst_n), .mode_i(mode),
        .raise_rms_i(raise), .active_cmp_i(acmp), .dead_cmp_i(dcmp), .seg_bits_i(bits),
        .seg_o(seg), .com_o(com), .com_oe_o(oe), .first_drive_event_o(e1),
        .inverted_drive_event_o(e2), .dead_interval_event_o(ed), .frame_start_o(fs));
    mlcd_glass #(.NSEG(NS)) u_glass (.clk_i(clk), .seg_i(seg), .com_i(com), .oe_i(oe), .dc_o(dc));
    function automatic int ncom(input int m);
        return (m == 0) ? 1 : (m == 1) ? 2 : 4;
    endfunction
    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // static mode expects no dead intervals, keeping its 50 percent duty
    task automatic apply(input int i);
        int n, a;
        logic [3:0] k, oh;
        logic [NS-1:0] row;
        mode = 2'(tm[i]);
        raise = tr[i];
        acmp = ta[i];
        dcmp = td[i];
        bits = 16'($random(seed));
        n = ncom(tm[i]);
        k = 4'((1 << n) - 1);
        a = (ta[i] == 0) ? 1 : ta[i];
        for (int c = 0; c < n; c++) begin
            row = bits[c*NS +: NS];
            oh = 4'(1 << c);
            q.push_back('{2'h0, c == 0, row, 4'h0, oh, k, a});
            if (n > 1 && td[i] > 0) q.push_back('{2'h1, 1'b0, {NS{tr[i]}}, 4'h0, k, k, td[i]});
            q.push_back('{2'h2, 1'b0, ~row, oh, oh, k, a});
            if (n > 1 && td[i] > 0) q.push_back('{2'h1, 1'b0, {NS{1'b0}}, tr[i] ? k : 4'h0, k, k, td[i]});
        end
    endtask
    always @(negedge clk) begin
        gap = gap + 1;
        if (arst_n === 1'b1 && (e1 | e2 | ed) === 1'b1) begin
            e = q.pop_front();
            chk({e2, ed} === e.kind && fs === e.fs, "event kind");
            chk(seg === e.seg, "segment drive");
            chk((com & e.oe) === e.com && (oe & e.msk) === e.oe, "common drive");
            if (plen > 0) chk(gap == plen, "interval length");
            plen = e.len;
            gap = 0;
            if (fs === 1'b1 && dcp_ok) chk(dc == dcp, "net dc over frame");
            if (fs === 1'b1) dcp = dc;
            dcp_ok = dcp_ok | fs;
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
        apply(0);
        // next settings land mid-frame, after the last row was taken
        for (int i = 1; i < 7; i++) begin
            @(posedge clk iff fs === 1'b1);
            if (i > 1) $display("test %0d done", i - 2);
            if (i < 6) begin
                repeat (ncom(tm[i-1]) - 1) @(posedge clk iff e1 === 1'b1);
                #1 apply(i);
            end
        end
        for (int t = 0; t < 200 && q.size() > 0; t++) @(posedge clk);
        $display("test %0d done", 5);
        chk(q.size() == 0, "notes left over");
        print_verdict;
    end
    initial begin
        // six short frames need under 300 cycles; 2500 leaves ample margin
        #20000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict;
    end
endmodule
